// >>> src/seq_defines.svh
// Timing, field and reset constants of the start-up sequencer.
// Assumes inclusion by bare name from the package and design modules.
`ifndef SEQ_DEFINES_SVH
`define SEQ_DEFINES_SVH

// Clock rates in hertz
`define SYS_CLK_HZ    250000000
`define TICK_HZ       32000
`define SW_CLK_HZ     2000000

// Sequencing times in microseconds, as typical values
`define TURN_ON_US    6000
`define FIRST_SLOT_US 2500
`define SLOT_STEP_US  1000
`define PG_DELAY_US   2000

// Converts microseconds into whole ticks of the derived tick
`define US_TO_TICKS(us) (((us) * `TICK_HZ) / 1000000)

// Oscillator trim step in percent of nominal
`define TRIM_PCT      3
`define PCT_BASE      100

// Field widths
`define SLOT_W        4
`define VOLT_W        8
`define TMR_W         8
`define TRIM_W        4
`define DIV_W         16

// Built-in default slots, rail 0 in the low nibble
`define DEF_SLOTS     40'h3332211114
`define DEF_VOLTS     80'h0

// Reset values
`define SLOT_RST      4'h0
`define VOLT_RST      8'h00

`endif

// >>> src/seq_pkg.sv
// Types shared by the start-up sequencer modules.
// Assumes seq_defines.svh is on the include path.
`include "seq_defines.svh"

package seq_pkg;
    typedef logic [`SLOT_W-1:0] slot_t;   // Sequence slot number
    typedef logic [`VOLT_W-1:0] volt_t;   // Rail voltage code
    typedef logic [`TMR_W-1:0]  tmr_t;    // Tick countdown

    // Sequencer phases
    typedef enum logic [3:0] {
        S_OFF, S_CLEAR, S_LOAD, S_TURN_ON, S_FIRST, S_SLOT, S_STEP, S_PG,
        S_ON
    } seq_state_e;
endpackage

// >>> src/tick_if.sv
// Carrier between the oscillator divider and the sequencer.
// Assumes both ends share sys_clk.
`include "seq_defines.svh"

interface tick_if;
    logic                     tick;     // Derived 32 kHz tick pulse
    logic                     sw_pulse; // Switching clock pulse
    logic signed [`TRIM_W-1:0] trim;    // Signed trim steps

    modport src (output tick, output sw_pulse, input trim);
    modport snk (input tick, input sw_pulse, output trim);
endinterface

// >>> src/osc_divider.sv
// Divides the master clock into the 32 kHz tick and the switching pulse.
// Assumes sys_clk stands for the trimmed master oscillator.
`include "seq_defines.svh"

module osc_divider
    import seq_pkg::*;
#(
    parameter int TICK_DIV = `SYS_CLK_HZ / `TICK_HZ,
    parameter int SW_DIV   = `SYS_CLK_HZ / `SW_CLK_HZ
) (
    input  wire logic sys_clk,  // Master clock
    input  wire logic rst,      // Async reset, active high
    input  wire logic ce,       // Clock enable
    tick_if.src       t         // Tick outputs, trim input
);
    logic [`DIV_W-1:0] tick_cnt_q, tick_cnt_d; // Tick divider count
    logic [`DIV_W-1:0] sw_cnt_q, sw_cnt_d;     // Switching divider count
    logic              tick_q, tick_d;         // Tick pulse
    logic              sw_q, sw_d;             // Switching pulse
    int                tick_lim;               // Trimmed tick period
    int                sw_lim;                 // Trimmed switching period

    // Trim shortens or stretches both periods by steps of nominal
    always_comb begin
        tick_lim = TICK_DIV
            - (TICK_DIV * `TRIM_PCT * int'(t.trim)) / `PCT_BASE;
        sw_lim   = SW_DIV - (SW_DIV * `TRIM_PCT * int'(t.trim)) / `PCT_BASE;
        tick_cnt_d = tick_cnt_q + 1'b1;
        sw_cnt_d   = sw_cnt_q + 1'b1;
        tick_d     = 1'b0;
        sw_d       = 1'b0;
        // Tick wraps at the trimmed period
        if (tick_cnt_q >= `DIV_W'(tick_lim - 1)) begin
            tick_cnt_d = '0;
            tick_d     = 1'b1;
        end
        // Switching pulse from the same master clock
        if (sw_cnt_q >= `DIV_W'(sw_lim - 1)) begin
            sw_cnt_d = '0;
            sw_d     = 1'b1;
        end
    end

    // Divider registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tick_cnt_q <= '0;
            sw_cnt_q   <= '0;
            tick_q     <= 1'b0;
            sw_q       <= 1'b0;
        end else if (ce) begin
            tick_cnt_q <= tick_cnt_d;
            sw_cnt_q   <= sw_cnt_d;
            tick_q     <= tick_d;
            sw_q       <= sw_d;
        end
    end

    assign t.tick     = tick_q;
    assign t.sw_pulse = sw_q;
endmodule

// >>> src/pmic_startup_sequencer.sv
// Start-up sequencer: loads rail settings, enables rails by slot and
// releases the open-drain power-good reset. Inputs are synchronous to
// sys_clk; slow_osc_tick is a one-cycle pulse of the untrimmed oscillator.
//
// Operation
// - Built-in start; host writes only after start-up
// - Host rewrites parameters used by RAM boot
// - Clear configuration to zero before loading
// - Boot flag resets zero, selects default set
// - Boot flag one loads from internal RAM
// - RAM boot needs supply, flag, enable edge
// - Slot zero keeps a rail off
// - Slot field is binary slot number
// - Delays 6.0, 2.5, then 1.0 ms
// - Release reset 2.0 ms after last slot
// - Untrimmed clock only in low-power conditions
// - Start-up timed by divided master tick
// - Debounce tick follows clock select, irq debouncers use untrimmed
// - Trim shifts master clock in three percent steps
// - Switching clock divided from master oscillator
// - Enable rising edge is the turn-on event
// - Reset driven low again only at turn-off
`include "seq_defines.svh"

module pmic_startup_sequencer
    import seq_pkg::*;
#(
    parameter int NUM_RAILS = 10,
    parameter int TICK_DIV  = `SYS_CLK_HZ / `TICK_HZ,
    parameter int SW_DIV    = `SYS_CLK_HZ / `SW_CLK_HZ
) (
    input  wire logic                 sys_clk,        // Master clock
    input  wire logic                 rst,            // First valid supply
    input  wire logic                 ce,             // Clock enable
    input  wire logic                 en_pin,         // Enable pin level
    input  wire logic                 vin_below_uv,   // Input under threshold
    input  wire logic                 all_sleep,      // All rails in sleep
    input  wire logic                 all_pfm,        // All rails pulse mode
    input  wire logic                 slow_osc_tick,  // Untrimmed 32 kHz
    input  wire logic [`TRIM_W-1:0]   trim_code,      // Signed trim steps
    input  wire logic                 host_wr,        // Host parameter write
    input  wire logic [`SLOT_W-1:0]   host_idx,       // Rail index
    input  wire logic [`SLOT_W-1:0]   host_slot,      // New slot field
    input  wire logic [`VOLT_W-1:0]   host_volt,      // New voltage code
    input  wire logic                 host_boot_wr,   // Boot flag write
    input  wire logic                 host_boot_val,  // Boot flag value
    input  wire logic                 pg_rst_in,      // Reset line level
    output logic [NUM_RAILS-1:0]      rail_en_q,      // Rail enables
    output logic [NUM_RAILS-1:0][`VOLT_W-1:0] rail_volt_q, // Rail volts
    output logic                      pg_rst_out_q,   // Reset drive level
    output logic                      pg_rst_oe_n_q,  // Low while driving
    output logic                      pg_sense_q,     // Reset line seen
    output logic                      seq_done_q,     // In the on state
    output logic                      ram_boot_select_q, // RAM boot flag
    output logic                      use_untrimmed_q,   // Slow clock in use
    output logic                      debounce_tick_q,   // Debounce tick
    output logic                      irq_debounce_tick_q, // Irq debounce
    output logic                      sw_clk_en_q     // Switching pulse
);
    localparam tmr_t TURN_ON_TICKS = tmr_t'(`US_TO_TICKS(`TURN_ON_US));
    localparam tmr_t FIRST_TICKS   = tmr_t'(`US_TO_TICKS(`FIRST_SLOT_US));
    localparam tmr_t STEP_TICKS    = tmr_t'(`US_TO_TICKS(`SLOT_STEP_US));
    localparam tmr_t PG_TICKS      = tmr_t'(`US_TO_TICKS(`PG_DELAY_US));
    localparam logic [NUM_RAILS*`SLOT_W-1:0] DEF_SLOTS = `DEF_SLOTS;
    localparam logic [NUM_RAILS*`VOLT_W-1:0] DEF_VOLTS = `DEF_VOLTS;

    tick_if t ();                               // Divider carrier

    seq_state_e          st_q, st_d;            // Sequencer phase
    tmr_t                tmr_q, tmr_d;          // Tick countdown
    slot_t               cur_q, cur_d;          // Current slot
    logic                en_q;                  // Previous enable level
    logic [NUM_RAILS-1:0] en_d;                 // Next rail enables
    logic                pg_d;                  // Next reset release
    logic                boot_d;                // Next boot flag
    slot_t               cfg_slot_q [NUM_RAILS]; // Live slot fields
    slot_t               cfg_slot_d [NUM_RAILS];
    volt_t               cfg_volt_d [NUM_RAILS]; // Next live volts
    slot_t               ram_slot_q [NUM_RAILS]; // Retained slot fields
    slot_t               ram_slot_d [NUM_RAILS];
    volt_t               ram_volt_q [NUM_RAILS]; // Retained volts
    volt_t               ram_volt_d [NUM_RAILS];
    logic [NUM_RAILS-1:0] slot_hit;             // Rail in current slot
    logic [NUM_RAILS-1:0] slot_above;           // Rail in a later slot
    logic                en_rise;               // Turn-on event
    logic                en_fall;               // Turn-off event
    logic                starting;              // Sequence in progress
    logic                unt_d;                 // Next clock select

    osc_divider #(.TICK_DIV(TICK_DIV), .SW_DIV(SW_DIV)) u_div (
        .sys_clk (sys_clk),
        .rst     (rst),
        .ce      (ce),
        .t       (t.src)
    );
    assign t.trim = trim_code;

    assign en_rise  = en_pin && !en_q;
    assign en_fall  = !en_pin && en_q;
    assign starting = (st_q != S_OFF) && (st_q != S_ON);

    // Per-rail slot comparison against the current slot
    for (genvar i = 0; i < NUM_RAILS; i++) begin : g_rail
        assign slot_hit[i]   = (cfg_slot_q[i] == cur_q)
                               && (cfg_slot_q[i] != `SLOT_RST);
        assign slot_above[i] = cfg_slot_q[i] > cur_q;
    end

    // Sequencer next state
    always_comb begin
        st_d       = st_q;
        tmr_d      = tmr_q;
        cur_d      = cur_q;
        en_d       = rail_en_q;
        pg_d       = pg_rst_oe_n_q;
        boot_d     = ram_boot_select_q;
        cfg_slot_d = cfg_slot_q;
        ram_slot_d = ram_slot_q;
        ram_volt_d = ram_volt_q;
        for (int i = 0; i < NUM_RAILS; i++) begin
            cfg_volt_d[i] = rail_volt_q[i];
        end
        case (st_q)
            S_OFF: begin
                if (en_rise) begin
                    st_d = S_CLEAR;
                end
            end
            S_CLEAR: begin
                for (int i = 0; i < NUM_RAILS; i++) begin
                    cfg_slot_d[i] = `SLOT_RST;
                    cfg_volt_d[i] = `VOLT_RST;
                end
                st_d = S_LOAD;
            end
            S_LOAD: begin
                for (int i = 0; i < NUM_RAILS; i++) begin
                    if (ram_boot_select_q) begin
                        cfg_slot_d[i] = ram_slot_q[i];
                        cfg_volt_d[i] = ram_volt_q[i];
                    end else begin
                        cfg_slot_d[i] = DEF_SLOTS[i*`SLOT_W +: `SLOT_W];
                        cfg_volt_d[i] = DEF_VOLTS[i*`VOLT_W +: `VOLT_W];
                    end
                end
                tmr_d = TURN_ON_TICKS;
                st_d  = S_TURN_ON;
            end
            S_TURN_ON: begin
                if (t.tick) begin
                    tmr_d = tmr_q - 1'b1;
                    if (tmr_q == tmr_t'(1)) begin
                        tmr_d = FIRST_TICKS;
                        st_d  = S_FIRST;
                    end
                end
            end
            S_FIRST: begin
                if (t.tick) begin
                    tmr_d = tmr_q - 1'b1;
                    if (tmr_q == tmr_t'(1)) begin
                        cur_d = slot_t'(1);
                        st_d  = S_SLOT;
                    end
                end
            end
            S_SLOT: begin
                en_d = rail_en_q | slot_hit;
                if (|slot_above) begin
                    tmr_d = STEP_TICKS;
                    st_d  = S_STEP;
                end else begin
                    tmr_d = PG_TICKS;
                    st_d  = S_PG;
                end
            end
            S_STEP: begin
                if (t.tick) begin
                    tmr_d = tmr_q - 1'b1;
                    if (tmr_q == tmr_t'(1)) begin
                        cur_d = cur_q + 1'b1;
                        st_d  = S_SLOT;
                    end
                end
            end
            S_PG: begin
                if (t.tick) begin
                    tmr_d = tmr_q - 1'b1;
                    if (tmr_q == tmr_t'(1)) begin
                        pg_d = 1'b1;
                        st_d = S_ON;
                    end
                end
            end
            S_ON: begin
                // Host access opens only once start-up is over
                if (host_wr && (int'(host_idx) < NUM_RAILS)) begin
                    ram_slot_d[host_idx] = host_slot;
                    ram_volt_d[host_idx] = host_volt;
                    cfg_volt_d[host_idx] = host_volt;
                end
                if (host_boot_wr) begin
                    boot_d = host_boot_val;
                end
            end
            default: st_d = S_OFF;
        endcase
        // Turn-off drops every rail and pulls the reset low
        if (en_fall && (st_q != S_OFF)) begin
            st_d = S_OFF;
            en_d = '0;
            pg_d = 1'b0;
        end
    end

    // Clock source selection for the debounce tick
    always_comb begin
        unt_d = vin_below_uv || ((all_sleep || all_pfm) && !starting);
    end

    // Sequencer registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_q                <= S_OFF;
            tmr_q               <= '0;
            cur_q               <= '0;
            en_q                <= 1'b0;
            rail_en_q           <= '0;
            rail_volt_q         <= '0;
            pg_rst_out_q        <= 1'b0;
            pg_rst_oe_n_q       <= 1'b0;
            pg_sense_q          <= 1'b0;
            seq_done_q          <= 1'b0;
            ram_boot_select_q   <= 1'b0;
            use_untrimmed_q     <= 1'b0;
            debounce_tick_q     <= 1'b0;
            irq_debounce_tick_q <= 1'b0;
            sw_clk_en_q         <= 1'b0;
            for (int i = 0; i < NUM_RAILS; i++) begin
                cfg_slot_q[i] <= `SLOT_RST;
                ram_slot_q[i] <= `SLOT_RST;
                ram_volt_q[i] <= `VOLT_RST;
            end
        end else if (ce) begin
            st_q                <= st_d;
            tmr_q               <= tmr_d;
            cur_q               <= cur_d;
            en_q                <= en_pin;
            rail_en_q           <= en_d;
            pg_rst_out_q        <= 1'b0;
            pg_rst_oe_n_q       <= pg_d;
            pg_sense_q          <= pg_rst_in;
            seq_done_q          <= (st_d == S_ON);
            ram_boot_select_q   <= boot_d;
            use_untrimmed_q     <= unt_d;
            debounce_tick_q     <= unt_d ? slow_osc_tick : t.tick;
            irq_debounce_tick_q <= slow_osc_tick;
            sw_clk_en_q         <= t.sw_pulse;
            cfg_slot_q          <= cfg_slot_d;
            ram_slot_q          <= ram_slot_d;
            ram_volt_q          <= ram_volt_d;
            for (int i = 0; i < NUM_RAILS; i++) begin
                rail_volt_q[i] <= cfg_volt_d[i];
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence load_s;
        ce && (st_q == S_LOAD) && !en_fall;
    endsequence
    sequence pg_done_s;
        ce && (st_q == S_PG) && t.tick && (tmr_q == tmr_t'(1)) && !en_fall;
    endsequence

    host_gate_a: assert property (ce && host_wr && (st_q != S_ON)
        |=> ram_slot_q[0] == $past(ram_slot_q[0]))
        else $error("host write taken before start-up finished");
    ram_write_a: assert property (ce && host_wr && (st_q == S_ON)
        && (host_idx == '0) |=> ram_slot_q[0] == $past(host_slot))
        else $error("host write did not reach retained parameters");
    clear_first_a: assert property (ce && (st_q == S_CLEAR)
        |=> cfg_slot_q[0] == `SLOT_RST)
        else $error("configuration not cleared before load");
    default_load_a: assert property (load_s and !ram_boot_select_q
        |=> cfg_slot_q[0] == DEF_SLOTS[`SLOT_W-1:0])
        else $error("default set not loaded");
    ram_load_a: assert property (load_s and ram_boot_select_q
        |=> cfg_slot_q[0] == $past(ram_slot_q[0]))
        else $error("retained set not loaded");
    turn_on_a: assert property (ce && (st_q == S_OFF) && !en_rise
        |=> st_q == S_OFF)
        else $error("sequence started without enable edge");
    zero_slot_a: assert property (rail_en_q[0]
        |-> cfg_slot_q[0] != `SLOT_RST)
        else $error("rail with slot zero was enabled");
    slot_enable_a: assert property (ce && (st_q == S_SLOT) && !en_fall
        |=> rail_en_q == ($past(rail_en_q) | $past(slot_hit)))
        else $error("slot rails not enabled together");
    delay_load_a: assert property (load_s |=> tmr_q == TURN_ON_TICKS
        ##0 st_q == S_TURN_ON)
        else $error("turn-on delay not started");
    pg_release_a: assert property ($rose(pg_rst_oe_n_q)
        |-> $past(st_q) == S_PG && $past(tmr_q) == tmr_t'(1))
        else $error("reset released outside its delay");
    pg_timing_a: assert property (pg_done_s |=> pg_rst_oe_n_q ##0 seq_done_q)
        else $error("reset not released when delay expired");
    clk_select_a: assert property (use_untrimmed_q && $past(ce)
        |-> $past(vin_below_uv || all_sleep || all_pfm))
        else $error("untrimmed clock chosen without cause");
    start_clk_a: assert property (ce && starting && !vin_below_uv
        |=> !use_untrimmed_q)
        else $error("start-up not timed by derived tick");
    pg_hold_a: assert property ($fell(pg_rst_oe_n_q)
        |-> $past(en_fall))
        else $error("reset reasserted without turn-off");
endmodule

// >>> testbench/host_reset_model.sv
// Host side of the open-drain power-good reset line.
// Assumes a pull-up on the line and an active-low output enable.
module host_reset_model (
    input  wire logic oe_n,   // Device output enable, low drives
    output logic      line    // Wire level seen by both parties
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-up wins while the device has released the line
    assign line = oe_n ? 1'b1 : 1'b0;
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench of the start-up sequencer with short dividers.
// Assumes seq_defines.svh on the include path; one 250 MHz clock.
`include "seq_defines.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import seq_pkg::*;
    logic sys_clk, rst, en_pin, vin_below_uv, all_sleep, slow_osc_tick;
    logic host_wr, host_boot_wr, host_boot_val, line;
    logic [3:0]      host_idx, host_slot;  // Write target and slot
    logic [7:0]      host_volt;            // Write voltage code
    logic [9:0]      rail_en_q;            // Rail enables seen
    logic [9:0][7:0] rail_volt_q, ram_v;   // Live and expected volts
    logic [9:0][3:0] def_sl, ram_sl;       // Slot tables of the model
    logic pg_out, oe_n, sense, done, flag, untr, dtick, itick, swp;
    int fail_count, n_compared, seed, i;
    // Design with eight-cycle tick and four-cycle switching pulse
    pmic_startup_sequencer #(.TICK_DIV(8), .SW_DIV(4))
        u_pmic_startup_sequencer (
        .sys_clk(sys_clk), .rst(rst), .ce(1'b1), .en_pin(en_pin),
        .vin_below_uv(vin_below_uv), .all_sleep(all_sleep),
        .all_pfm(1'b0), .slow_osc_tick(slow_osc_tick),
        .trim_code(4'h0), .host_wr(host_wr), .host_idx(host_idx),
        .host_slot(host_slot), .host_volt(host_volt),
        .host_boot_wr(host_boot_wr), .host_boot_val(host_boot_val),
        .pg_rst_in(line), .rail_en_q(rail_en_q),
        .rail_volt_q(rail_volt_q), .pg_rst_out_q(pg_out),
        .pg_rst_oe_n_q(oe_n), .pg_sense_q(sense), .seq_done_q(done),
        .ram_boot_select_q(flag), .use_untrimmed_q(untr),
        .debounce_tick_q(dtick), .irq_debounce_tick_q(itick),
        .sw_clk_en_q(swp));
    host_reset_model u_host_reset_model (.oe_n(oe_n), .line(line));
    // Clock, 4 ns period
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Untrimmed oscillator pulse every 20 cycles
    initial begin
        slow_osc_tick = 1'b0;
        forever begin
            repeat (19) @(posedge sys_clk);
            #1 slow_osc_tick = 1'b1;
            @(posedge sys_clk);
            #1 slow_osc_tick = 1'b0;
        end
    end
    // Closing report and end of run
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Single comparison point
    task automatic check(input logic [95:0] seen, input logic [95:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // One clock, inputs change 1 ns after the edge
    task automatic step;
        @(posedge sys_clk);
        #1;
    endtask
    // Waits for a change of enables or release, counting ticks
    task automatic tick_wait(inout int tk, input logic [10:0] prev);
        int n;
        for (n = 0; {oe_n, rail_en_q} === prev; n++) begin
            if (n > 6000) begin
                fail_count++;
                give_verdict();
            end
            step();
            if (dtick === 1'b1) tk++;
        end
    endtask
    // Host parameter write, live volts follow one edge later
    task automatic hwrite(input int r, input logic [3:0] s,
                          input logic [7:0] v);
        host_idx = r[3:0];
        host_slot = s;
        host_volt = v;
        host_wr = 1'b1;
        step();
        check(rail_volt_q[r], v);
    endtask
    // Full power-up against the slot table model
    task automatic run_seq(input logic [9:0][3:0] sl,
                           input logic [9:0][7:0] vx);
        int s, tk, mx;
        logic [9:0] exp, prev;
        tk = 0;
        mx = 0;
        prev = '0;
        en_pin = 1'b1;
        step();
        // Write during start-up is ignored
        hwrite_quiet(vx);
        for (i = 0; i < 10; i++) if (sl[i] > mx) mx = sl[i];
        for (s = 1; s <= mx; s++) begin
            exp = '0;
            for (i = 0; i < 10; i++) exp[i] = (sl[i] == s);
            tick_wait(tk, {1'b0, prev});
            check(rail_en_q, prev | exp);
            if (s == 1) check(tk >= 270 && tk <= 273, 1);
            else check(tk, 32);
            prev = prev | exp;
            tk = 0;
        end
        tick_wait(tk, {1'b0, prev});
        check(tk, 64);
        check({oe_n, done, pg_out, rail_en_q}, {2'b11, 1'b0, prev});
        step();
        check(sense, 1'b1);
        check(rail_volt_q, vx);
        $display("power-up done");
    endtask
    // Refused write and flag write while sequencing
    task automatic hwrite_quiet(input logic [9:0][7:0] vx);
        host_idx = 4'h1;
        host_volt = ~vx[1];
        host_wr = 1'b1;
        host_boot_wr = 1'b1;
        host_boot_val = ~flag;
        step();
        host_wr = 1'b0;
        host_boot_wr = 1'b0;
        step();
        check({flag, rail_volt_q[1]}, {~host_boot_val, vx[1]});
    endtask
    // Turn-off drives the reset line low again
    task automatic turn_off;
        en_pin = 1'b0;
        step();
        step();
        check({oe_n, rail_en_q, line}, 12'h0);
        $display("turn-off done");
    endtask
    initial begin
        seed = 32'hef57;
        {rst, en_pin, vin_below_uv, all_sleep, host_wr} = 5'b10000;
        {host_boot_wr, host_boot_val, host_idx, host_slot} = '0;
        host_volt = '0;
        def_sl = `DEF_SLOTS;
        repeat (12) step();
        rst = 1'b0;
        check({flag, oe_n, rail_en_q, rail_volt_q}, '0);
        run_seq(def_sl, '0);
        // Rewrite every rail, slots 0..3 repeating
        for (i = 0; i < 10; i++) begin
            ram_sl[i] = i % 4;
            ram_v[i] = $random(seed);
            hwrite(i, ram_sl[i], ram_v[i]);
        end
        host_wr = 1'b0;
        host_boot_val = 1'b1;
        host_boot_wr = 1'b1;
        step();
        host_boot_wr = 1'b0;
        check({flag, oe_n}, 2'b11);
        // Low-power clock selection in the on state
        all_sleep = 1'b1;
        repeat (2) step();
        check(untr, 1'b1);
        all_sleep = 1'b0;
        repeat (2) step();
        check(untr, 1'b0);
        vin_below_uv = 1'b1;
        repeat (2) step();
        check(untr, 1'b1);
        vin_below_uv = 1'b0;
        for (i = 0; i < 200 && itick !== 1'b1; i++) step();
        check(itick, 1'b1);
        $display("clock selection done");
        turn_off();
        run_seq(ram_sl, ram_v);
        turn_off();
        rst = 1'b1;
        step();
        rst = 1'b0;
        check({flag, oe_n, rail_volt_q}, '0);
        run_seq(def_sl, '0);
        give_verdict();
    end
endmodule
